// ==== afe_pkg.sv ====
package afe_pkg;
  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [15:0] REG_IDX_AFE_CTRL   = 16'h0185;
  localparam int          BYTE_PER_WORD      = 4;
  localparam int          POS_VOLT_GAIN      = 7;
  localparam int          POS_CUR_GAIN_LSB   = 0;
  localparam int          POS_CLK_SEL_LSB    = 16;
  localparam int          POS_CUR_CONV_EN    = 24;
  localparam int          POS_VOLT_CONV_EN   = 26;
  localparam logic        RST_VOLT_GAIN      = 1'b0;
  localparam logic [1:0]  RST_CUR_GAIN       = 2'b00;
  localparam logic [1:0]  RST_CLK_SEL        = 2'b00;
  localparam logic        RST_CONV_EN        = 1'b0;
  // ------------------------------------------------------------
  // sampling clock select codes
  // ------------------------------------------------------------
  localparam logic [1:0]  SEL_DIV4           = 2'b00;
  localparam logic [1:0]  SEL_DIV8           = 2'b01;
  localparam logic [1:0]  SEL_DIV16          = 2'b10;
  localparam logic [3:0]  LAST_DIV4          = 4'h3;
  localparam logic [3:0]  LAST_DIV8          = 4'h7;
  localparam logic [3:0]  LAST_DIV16         = 4'hF;
  // ------------------------------------------------------------
  // bus answers
  // ------------------------------------------------------------
  localparam logic [1:0]  RESP_OKAY          = 2'b00;
  localparam logic [1:0]  RESP_SLVERR        = 2'b10;
endpackage

// ==== afe_clk_div.sv ====
`timescale 1ns/100ps
module afe_clk_div (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       meter_tick,
  input  wire logic [1:0] clk_sel,
  output wire logic       conv_tick
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [3:0] cnt;
    logic       pulse;
  } afe_div_st_t;

  afe_div_st_t st_ff;
  afe_div_st_t nxt_st;

  // code 11 is reserved; it runs as the slowest rate
  function automatic logic [3:0] div_last(input logic [1:0] sel);
    unique case (sel)
      afe_pkg::SEL_DIV4: div_last = afe_pkg::LAST_DIV4;
      afe_pkg::SEL_DIV8: div_last = afe_pkg::LAST_DIV8;
      default:           div_last = afe_pkg::LAST_DIV16;
    endcase
  endfunction

  // ------------------------------------------------------------
  // divider: counts metering ticks only
  // ------------------------------------------------------------
  always_comb
  begin
    nxt_st       = st_ff;
    nxt_st.pulse = 1'b0;
    if (meter_tick)
    begin
      if (st_ff.cnt >= div_last(clk_sel))
      begin
        nxt_st.cnt   = 4'h0;
        nxt_st.pulse = 1'b1;
      end
      else
      begin
        nxt_st.cnt = st_ff.cnt + 4'h1;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  assign conv_tick = st_ff.pulse;

  AST_DIV_GAP: assert property (@(posedge clk) disable iff (rst)
    conv_tick |=> !conv_tick ##1 !conv_tick ##1 !conv_tick)
    else $error("converter tick closer than four metering ticks");

  AST_DIV_CAUSE: assert property (@(posedge clk) disable iff (rst)
    conv_tick |-> $past(meter_tick))
    else $error("converter tick without a metering tick");
endmodule

// ==== afe_ctrl.sv ====
// Function
// - bit 7 selects voltage gain: 0 gives x4, 1 gives x1; resets to 0
// - bits 1:0 select current gain x32, x16, x4, x1; reset 0
// - bit 26 enables voltage converter; resets disabled
// - voltage converter enable clears itself in sleep and current-detection mode
// - bit 24 enables current converter; resets disabled
// - current converter enable clears in sleep, sets in current-detection mode
// - converter clock divides metering clock, default one quarter
// - bits 17:16 pick quarter, eighth or sixteenth of metering clock
// - both converter streams go to the phase compensation stage
// - metering clock from crystal or RC; halts when both stop
//
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/100ps
module afe_ctrl #(
  parameter int ADDR_W = 12
) (
  input  wire logic              REF_CLK,
  input  wire logic              RST,
  input  wire logic [ADDR_W-1:0] AWADDR,
  input  wire logic [2:0]        AWPROT,
  input  wire logic              AWVALID,
  output wire logic              AWREADY,
  input  wire logic [31:0]       WDATA,
  input  wire logic [3:0]        WSTRB,
  input  wire logic              WVALID,
  output wire logic              WREADY,
  output wire logic [1:0]        BRESP,
  output wire logic              BVALID,
  input  wire logic              BREADY,
  input  wire logic [ADDR_W-1:0] ARADDR,
  input  wire logic [2:0]        ARPROT,
  input  wire logic              ARVALID,
  output wire logic              ARREADY,
  output wire logic [31:0]       RDATA,
  output wire logic [1:0]        RRESP,
  output wire logic              RVALID,
  input  wire logic              RREADY,
  input  wire logic              CRYSTAL_CLOCK_TICK,
  input  wire logic              CRYSTAL_CLOCK_RUN,
  input  wire logic              RC_OSCILLATOR_CLOCK_TICK,
  input  wire logic              RC_OSCILLATOR_CLOCK_RUN,
  input  wire logic              SLEEP_MODE,
  input  wire logic              CURRENT_DETECT_MODE,
  input  wire logic              VOLTAGE_BITSTREAM,
  input  wire logic              CURRENT_BITSTREAM,
  output wire logic              VOLTAGE_ANALOG_GAIN,
  output wire logic [1:0]        CURRENT_ANALOG_GAIN,
  output wire logic              VOLTAGE_CONVERTER_ENABLE,
  output wire logic              CURRENT_CONVERTER_ENABLE,
  output wire logic [1:0]        SAMPLING_CLOCK_SELECT,
  output wire logic              CONVERTER_SAMPLING_CLOCK,
  output wire logic              PHC_VOLTAGE_BIT,
  output wire logic              PHC_CURRENT_BIT,
  output wire logic              PHC_STROBE
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic              aw_held;
    logic [ADDR_W-1:0] aw_addr;
    logic              w_held;
    logic [31:0]       w_data;
    logic [3:0]        w_strb;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
    logic              volt_gain;
    logic [1:0]        cur_gain;
    logic [1:0]        clk_sel;
    logic              volt_en;
    logic              cur_en;
    logic              volt_bit;
    logic              cur_bit;
    logic              strobe;
  } afe_st_t;

  afe_st_t st_ff;
  afe_st_t nxt_st;
  logic    meter_tick;
  logic    conv_tick;

  // AXI prot is accepted but carries no meaning for this block
  function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
    addr_hit = (a == ADDR_W'(afe_pkg::REG_IDX_AFE_CTRL * afe_pkg::BYTE_PER_WORD));
  endfunction

  function automatic logic [31:0] reg_word(input afe_st_t s);
    reg_word = 32'h0000_0000;
    reg_word[afe_pkg::POS_VOLT_GAIN]                          = s.volt_gain;
    reg_word[afe_pkg::POS_CUR_GAIN_LSB +: 2]                  = s.cur_gain;
    reg_word[afe_pkg::POS_CLK_SEL_LSB +: 2]                   = s.clk_sel;
    reg_word[afe_pkg::POS_CUR_CONV_EN]                        = s.cur_en;
    reg_word[afe_pkg::POS_VOLT_CONV_EN]                       = s.volt_en;
  endfunction

  // ------------------------------------------------------------
  // metering clock source and converter clock divider
  // ------------------------------------------------------------
  // crystal preferred; no source running means no ticks, so all stops
  assign meter_tick = CRYSTAL_CLOCK_RUN ? CRYSTAL_CLOCK_TICK
                    : (RC_OSCILLATOR_CLOCK_RUN & RC_OSCILLATOR_CLOCK_TICK);

  afe_clk_div u_div (
    .clk        (REF_CLK),
    .rst        (RST),
    .meter_tick (meter_tick),
    .clk_sel    (st_ff.clk_sel),
    .conv_tick  (conv_tick)
  );

  // ------------------------------------------------------------
  // bus slave and control register
  // ------------------------------------------------------------
  assign AWREADY = !st_ff.aw_held && !st_ff.bvalid;
  assign WREADY  = !st_ff.w_held && !st_ff.bvalid;
  assign ARREADY = !st_ff.rvalid;

  always_comb
  begin
    nxt_st = st_ff;
    if (AWVALID && AWREADY)
    begin
      nxt_st.aw_held = 1'b1;
      nxt_st.aw_addr = AWADDR;
    end
    if (WVALID && WREADY)
    begin
      nxt_st.w_held = 1'b1;
      nxt_st.w_data = WDATA;
      nxt_st.w_strb = WSTRB;
    end
    if (st_ff.bvalid && BREADY)
      nxt_st.bvalid = 1'b0;
    if (st_ff.aw_held && st_ff.w_held && !st_ff.bvalid)
    begin
      nxt_st.aw_held = 1'b0;
      nxt_st.w_held  = 1'b0;
      nxt_st.bvalid  = 1'b1;
      nxt_st.bresp   = afe_pkg::RESP_SLVERR;
      if (addr_hit(st_ff.aw_addr))
      begin
        nxt_st.bresp = afe_pkg::RESP_OKAY;
        if (st_ff.w_strb[0])
        begin
          nxt_st.volt_gain = st_ff.w_data[afe_pkg::POS_VOLT_GAIN];
          nxt_st.cur_gain  = st_ff.w_data[afe_pkg::POS_CUR_GAIN_LSB +: 2];
        end
        if (st_ff.w_strb[2])
          nxt_st.clk_sel = st_ff.w_data[afe_pkg::POS_CLK_SEL_LSB +: 2];
        if (st_ff.w_strb[3])
        begin
          nxt_st.volt_en = st_ff.w_data[afe_pkg::POS_VOLT_CONV_EN];
          nxt_st.cur_en  = st_ff.w_data[afe_pkg::POS_CUR_CONV_EN];
        end
      end
    end
    // low-power modes override software for as long as they last
    if (SLEEP_MODE)
    begin
      nxt_st.volt_en = 1'b0;
      nxt_st.cur_en  = 1'b0;
    end
    else if (CURRENT_DETECT_MODE)
    begin
      nxt_st.volt_en = 1'b0;
      nxt_st.cur_en  = 1'b1;
    end
    if (st_ff.rvalid && RREADY)
      nxt_st.rvalid = 1'b0;
    if (ARVALID && ARREADY)
    begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rdata  = addr_hit(ARADDR) ? reg_word(st_ff) : 32'h0000_0000;
      nxt_st.rresp  = addr_hit(ARADDR) ? afe_pkg::RESP_OKAY : afe_pkg::RESP_SLVERR;
    end
    // ----------------------------------------------------------
    // streams to phase compensation, sampled on converter ticks
    // ----------------------------------------------------------
    nxt_st.strobe = conv_tick;
    if (!st_ff.volt_en)
      nxt_st.volt_bit = 1'b0;
    else if (conv_tick)
      nxt_st.volt_bit = VOLTAGE_BITSTREAM;
    if (!st_ff.cur_en)
      nxt_st.cur_bit = 1'b0;
    else if (conv_tick)
      nxt_st.cur_bit = CURRENT_BITSTREAM;
  end

  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      st_ff           <= '0;
      st_ff.volt_gain <= afe_pkg::RST_VOLT_GAIN;
      st_ff.cur_gain  <= afe_pkg::RST_CUR_GAIN;
      st_ff.clk_sel   <= afe_pkg::RST_CLK_SEL;
      st_ff.volt_en   <= afe_pkg::RST_CONV_EN;
      st_ff.cur_en    <= afe_pkg::RST_CONV_EN;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign BVALID                   = st_ff.bvalid;
  assign BRESP                    = st_ff.bresp;
  assign RVALID                   = st_ff.rvalid;
  assign RDATA                    = st_ff.rdata;
  assign RRESP                    = st_ff.rresp;
  assign VOLTAGE_ANALOG_GAIN      = st_ff.volt_gain;
  assign CURRENT_ANALOG_GAIN      = st_ff.cur_gain;
  assign VOLTAGE_CONVERTER_ENABLE = st_ff.volt_en;
  assign CURRENT_CONVERTER_ENABLE = st_ff.cur_en;
  assign SAMPLING_CLOCK_SELECT    = st_ff.clk_sel;
  assign CONVERTER_SAMPLING_CLOCK = conv_tick;
  assign PHC_VOLTAGE_BIT          = st_ff.volt_bit;
  assign PHC_CURRENT_BIT          = st_ff.cur_bit;
  assign PHC_STROBE               = st_ff.strobe;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  logic wr_fire;
  assign wr_fire = st_ff.aw_held && st_ff.w_held && !st_ff.bvalid && addr_hit(st_ff.aw_addr);

  AST_VGAIN_WR: assert property (@(posedge REF_CLK) disable iff (RST)
    wr_fire && st_ff.w_strb[0] |=> VOLTAGE_ANALOG_GAIN == $past(st_ff.w_data[7]))
    else $error("voltage gain not taken from write");

  AST_IGAIN_WR: assert property (@(posedge REF_CLK) disable iff (RST)
    wr_fire && st_ff.w_strb[0] |=> CURRENT_ANALOG_GAIN == $past(st_ff.w_data[1:0]))
    else $error("current gain not taken from write");

  AST_VEN_WR: assert property (@(posedge REF_CLK) disable iff (RST)
    wr_fire && st_ff.w_strb[3] && !SLEEP_MODE && !CURRENT_DETECT_MODE
    |=> VOLTAGE_CONVERTER_ENABLE == $past(st_ff.w_data[26]))
    else $error("voltage converter enable not taken from write");

  AST_IEN_WR: assert property (@(posedge REF_CLK) disable iff (RST)
    wr_fire && st_ff.w_strb[3] && !SLEEP_MODE && !CURRENT_DETECT_MODE
    |=> CURRENT_CONVERTER_ENABLE == $past(st_ff.w_data[24]))
    else $error("current converter enable not taken from write");

  AST_SLEEP_OFF: assert property (@(posedge REF_CLK) disable iff (RST)
    SLEEP_MODE |=> !VOLTAGE_CONVERTER_ENABLE && !CURRENT_CONVERTER_ENABLE)
    else $error("converter left enabled in sleep");

  AST_DETECT_SET: assert property (@(posedge REF_CLK) disable iff (RST)
    CURRENT_DETECT_MODE && !SLEEP_MODE
    |=> CURRENT_CONVERTER_ENABLE && !VOLTAGE_CONVERTER_ENABLE)
    else $error("enables wrong in current detection");

  AST_CLKSEL_WR: assert property (@(posedge REF_CLK) disable iff (RST)
    wr_fire && st_ff.w_strb[2] |=> SAMPLING_CLOCK_SELECT == $past(st_ff.w_data[17:16]))
    else $error("sampling clock select not taken from write");

  AST_HALT: assert property (@(posedge REF_CLK) disable iff (RST)
    (!CRYSTAL_CLOCK_RUN && !RC_OSCILLATOR_CLOCK_RUN) [*2] |=> !CONVERTER_SAMPLING_CLOCK)
    else $error("converter clock runs with no metering source");

  AST_STREAM: assert property (@(posedge REF_CLK) disable iff (RST)
    conv_tick && VOLTAGE_CONVERTER_ENABLE
    |=> PHC_STROBE && PHC_VOLTAGE_BIT == $past(VOLTAGE_BITSTREAM))
    else $error("voltage stream not forwarded");

  AST_ZERO: assert property (@(posedge REF_CLK) disable iff (RST)
    !CURRENT_CONVERTER_ENABLE |=> !PHC_CURRENT_BIT)
    else $error("disabled current channel not zero");

  AST_CSTREAM: assert property (@(posedge REF_CLK) disable iff (RST)
    conv_tick && CURRENT_CONVERTER_ENABLE
    |=> PHC_STROBE && PHC_CURRENT_BIT == $past(CURRENT_BITSTREAM))
    else $error("current stream not forwarded");

  AST_VZERO: assert property (@(posedge REF_CLK) disable iff (RST)
    !VOLTAGE_CONVERTER_ENABLE |=> !PHC_VOLTAGE_BIT)
    else $error("disabled voltage channel not zero");

  // defaults checked at the first edge after release, before any write can land
  AST_RST_DFLT: assert property (@(posedge REF_CLK)
    $past(RST) && !RST
    |-> VOLTAGE_ANALOG_GAIN == afe_pkg::RST_VOLT_GAIN
      && CURRENT_ANALOG_GAIN == afe_pkg::RST_CUR_GAIN
      && VOLTAGE_CONVERTER_ENABLE == afe_pkg::RST_CONV_EN
      && CURRENT_CONVERTER_ENABLE == afe_pkg::RST_CONV_EN
      && SAMPLING_CLOCK_SELECT == afe_pkg::RST_CLK_SEL)
    else $error("control register not at reset value after reset");

  AST_CFG_HOLD: assert property (@(posedge REF_CLK) disable iff (RST)
    !wr_fire |=> $stable({VOLTAGE_ANALOG_GAIN, CURRENT_ANALOG_GAIN, SAMPLING_CLOCK_SELECT}))
    else $error("configuration changed without a write");

  COV_WRITE: cover property (@(posedge REF_CLK) disable iff (RST) wr_fire ##1 BVALID);
  COV_DETECT: cover property (@(posedge REF_CLK) disable iff (RST)
    CURRENT_DETECT_MODE ##1 CURRENT_CONVERTER_ENABLE);
  COV_STREAM: cover property (@(posedge REF_CLK) disable iff (RST)
    PHC_STROBE && PHC_VOLTAGE_BIT && PHC_CURRENT_BIT);
  COV_SLEEP: cover property (@(posedge REF_CLK) disable iff (RST)
    SLEEP_MODE && CURRENT_DETECT_MODE ##1 !CURRENT_CONVERTER_ENABLE);
  COV_READ: cover property (@(posedge REF_CLK) disable iff (RST)
    ARVALID && ARREADY ##1 RVALID);
endmodule

// ==== afe_sensor_model.sv ====
`timescale 1ns/100ps
// ----
// sensor side: metering clock ticks and converter bit streams
// ----
module afe_sensor_model (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic xtal_run,
  input  wire logic rc_run,
  output wire logic xtal_tick,
  output wire logic rc_tick,
  output wire logic volt_bit,
  output wire logic cur_bit
);
  logic phase_ff;
  logic cur_ff;

  // the two sources tick on opposite phases so a wrong pick shifts the pulses
  assign xtal_tick = xtal_run & phase_ff;
  assign rc_tick   = rc_run & ~phase_ff;
  assign volt_bit  = 1'b1;
  assign cur_bit   = cur_ff;

  // current stream changes every tick, so a stale sample is caught
  always_ff @(posedge clk)
  begin
    phase_ff <= rst ? 1'b0 : ~phase_ff;
    cur_ff   <= rst ? 1'b0 : cur_ff ^ xtal_tick ^ rc_tick;
  end
endmodule

// ==== adc_front_end_control_tb.sv ====
`timescale 1ns/100ps
module adc_front_end_control_tb;
  localparam logic [11:0] A = 12'(afe_pkg::REG_IDX_AFE_CTRL * afe_pkg::BYTE_PER_WORD);
  localparam logic [31:0] RW[10] = '{32'h0, 32'hFFFF_FFFF, 32'h80, 32'h1, 32'h2, 32'h3,
    32'h0001_0000, 32'h0002_0000, 32'h0400_0000, 32'h0100_0000};
  localparam logic [31:0] RR[10] = '{32'h0, 32'h0503_0083, 32'h80, 32'h1, 32'h2, 32'h3,
    32'h0001_0000, 32'h0002_0000, 32'h0400_0000, 32'h0100_0000};
  logic        clk, rst, xrun, rcrun, sleep, cdm;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rd;
  logic [3:0]  wstrb;
  logic [1:0]  resp;
  wire logic   xt, rt, vb, cb, awr, wr_r, bv, arr, rv, vg, ve, ce, sc, pv, pc, ps;
  wire logic [1:0]  br, rr, cg, cs;
  wire logic [31:0] rdata;
  int          fails, cmp_count, n;

  afe_sensor_model u_sensor (.clk(clk), .rst(rst), .xtal_run(xrun), .rc_run(rcrun),
    .xtal_tick(xt), .rc_tick(rt), .volt_bit(vb), .cur_bit(cb));

  afe_ctrl u_dut (.REF_CLK(clk), .RST(rst), .AWADDR(awaddr), .AWPROT(3'h0),
    .AWVALID(awvalid), .AWREADY(awr), .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid),
    .WREADY(wr_r), .BRESP(br), .BVALID(bv), .BREADY(bready), .ARADDR(araddr),
    .ARPROT(3'h0), .ARVALID(arvalid), .ARREADY(arr), .RDATA(rdata), .RRESP(rr),
    .RVALID(rv), .RREADY(rready), .CRYSTAL_CLOCK_TICK(xt), .CRYSTAL_CLOCK_RUN(xrun),
    .RC_OSCILLATOR_CLOCK_TICK(rt), .RC_OSCILLATOR_CLOCK_RUN(rcrun), .SLEEP_MODE(sleep),
    .CURRENT_DETECT_MODE(cdm), .VOLTAGE_BITSTREAM(vb), .CURRENT_BITSTREAM(cb),
    .VOLTAGE_ANALOG_GAIN(vg), .CURRENT_ANALOG_GAIN(cg), .VOLTAGE_CONVERTER_ENABLE(ve),
    .CURRENT_CONVERTER_ENABLE(ce), .SAMPLING_CLOCK_SELECT(cs),
    .CONVERTER_SAMPLING_CLOCK(sc), .PHC_VOLTAGE_BIT(pv), .PHC_CURRENT_BIT(pc),
    .PHC_STROBE(ps));

  // ----
  // helpers
  // ----
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // handshakes are judged at the falling edge, where nothing is in motion
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    tb = 1'b0;
    while (!tb)
    begin
      @(negedge clk);
      ta = awvalid & awr;
      tw = wvalid & wr_r;
      tb = bv & bready;
      resp = br;
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) bready <= 1'b0;
    end
  endtask

  task automatic rdr(input logic [11:0] a);
    logic ta, tr;
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    tr = 1'b0;
    while (!tr)
    begin
      @(negedge clk);
      ta = arvalid & arr;
      tr = rv & rready;
      rd = rdata;
      resp = rr;
      @(posedge clk);
      if (ta) arvalid <= 1'b0;
      if (tr) rready <= 1'b0;
    end
  endtask

  // first gap may be short after a select change, so the third one is measured
  task automatic per(input int exp);
    for (int k = 0; k < 3; k++)
    begin
      n = 0;
      do
      begin
        @(negedge clk);
        n++;
      end while (!sc && n < 200);
    end
    chk(32'(n), 32'(exp));
    @(posedge clk);
  endtask

  task automatic strm(input logic exp_v);
    logic cap;
    repeat (4)
    begin
      n = 0;
      do
      begin
        @(negedge clk);
        n++;
      end while (!sc && n < 200);
      cap = cb;
      @(negedge clk);
      chk(32'({ps, pv, pc}), 32'({1'b1, exp_v, cap}));
    end
    @(posedge clk);
  endtask

  task automatic ports(input logic [31:0] e);
    chk(32'({ve, ce, cs, vg, cg}), 32'({e[26], e[24], e[17:16], e[7], e[1:0]}));
  endtask

  // ----
  // stimulus
  // ----
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  initial
  begin
    #(50 * 40000);
    fails++;
    give_verdict;
  end

  initial
  begin
    {rst, xrun, rcrun, sleep, cdm} = 5'b11000;
    {awvalid, wvalid, bready, arvalid, rready} = 5'b0;
    {awaddr, araddr, wdata, wstrb} = {24'h0, 32'h0, 4'hF};
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rdr(A);
    chk(rd, 32'h0);
    ports(32'h0);
    per(8);
    for (int i = 0; i < 10; i++)
    begin
      wr(A, RW[i]);
      chk(32'(resp), 32'(afe_pkg::RESP_OKAY));
      rdr(A);
      chk(rd, RR[i]);
      ports(RR[i]);
    end
    wr(A, 32'h0001_0000);
    per(16);
    wr(A, 32'h0002_0000);
    per(32);
    wstrb <= 4'h1;
    wr(A, 32'hFFFF_FFFF);
    wstrb <= 4'hF;
    rdr(A);
    chk(rd, 32'h0002_0083);
    wr(12'h0, 32'hFFFF_FFFF);
    chk(32'(resp), 32'(afe_pkg::RESP_SLVERR));
    rdr(12'h0);
    chk(rd, 32'h0);
    chk(32'(resp), 32'(afe_pkg::RESP_SLVERR));
    // bandgap is taken as already enabled before any converter enable
    wr(A, 32'h0100_0000);
    strm(1'b0);
    wr(A, 32'h0500_0000);
    strm(1'b1);
    xrun  <= 1'b0;
    rcrun <= 1'b1;
    per(8);
    rcrun <= 1'b0;
    repeat (4) @(negedge clk);
    n = 0;
    repeat (64)
    begin
      @(negedge clk);
      n += int'(sc);
    end
    chk(32'(n), 32'h0);
    @(posedge clk);
    xrun  <= 1'b1;
    sleep <= 1'b1;
    repeat (2) @(posedge clk);
    wr(A, 32'h0500_0000);
    @(negedge clk);
    chk(32'({ve, ce}), 32'h0000_0000);
    @(posedge clk);
    sleep <= 1'b0;
    repeat (2) @(negedge clk);
    chk(32'({ve, ce}), 32'h0000_0000);
    @(posedge clk);
    wr(A, 32'h0402_0000);
    chk(32'({ve, ce}), 32'h0000_0002);
    cdm <= 1'b1;
    repeat (2) @(negedge clk);
    chk(32'({ve, ce}), 32'h0000_0001);
    @(posedge clk);
    sleep <= 1'b1;
    repeat (2) @(negedge clk);
    chk(32'({ve, ce}), 32'h0000_0000);
    @(posedge clk);
    {sleep, cdm} <= 2'b00;
    // mid-run reset: every field falls back to its reset value
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    ports(32'h0000_0000);
    @(posedge clk);
    rdr(A);
    chk(rd, 32'h0000_0000);
    give_verdict;
  end
endmodule
